// ---- common/wdg_pkg.sv ----
// constants shared by the watchdog and its tick divider
package wdg_pkg;
  ////////////////////////////////////////////////////////////////////////////
  // clocking
  localparam int CLK_FREQ_HZ = 200_000_000;  // pclk rate
  localparam int LSO_FREQ_HZ = 125_000;      // low-speed oscillator rate
  localparam int LSO_DIV     = CLK_FREQ_HZ / LSO_FREQ_HZ;  // pclk cycles per osc tick
  ////////////////////////////////////////////////////////////////////////////
  // counter and prescaler
  localparam int              CNT_W       = 15;
  localparam int              PSC_W       = 7;
  localparam logic [14:0]     FULL_UNPROT = 15'h7FFF;  // 32768 ticks to underflow
  localparam logic [14:0]     FULL_PROT   = 15'h0FFF;  // 4096 ticks to underflow
  localparam logic [6:0]      PSC_MASK16  = 7'h0F;
  localparam logic [6:0]      PSC_MASK128 = 7'h7F;
  localparam logic [7:0]      REFRESH_ARM  = 8'h00;
  localparam logic [7:0]      REFRESH_FIRE = 8'hFF;
  ////////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam int          ADDR_W      = 8;
  localparam logic [7:0]  OFF_REFRESH = 8'h00;
  localparam logic [7:0]  OFF_START   = 8'h04;
  localparam logic [7:0]  OFF_WDCTRL  = 8'h08;
  localparam logic [7:0]  OFF_PMODE1  = 8'h0C;
  localparam logic [7:0]  OFF_PROTECT = 8'h10;
  localparam logic [7:0]  OFF_CMODE1  = 8'h14;
  localparam logic [7:0]  OFF_OPTION  = 8'h18;
  localparam logic [7:0]  OFF_COUNT   = 8'h1C;
  localparam logic [7:0]  OFF_STATUS  = 8'h20;
  ////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int PRESEL_BIT    = 7;
  localparam int URS_BIT       = 2;
  localparam int PROT_BIT      = 7;
  localparam int STOP_BIT      = 0;
  localparam int LSO_OFF_BIT   = 4;
  localparam int OPT_AUTO_BIT  = 0;
  localparam int OPT_PROT_BIT  = 7;
  localparam int STAT_RUN_BIT  = 0;
  localparam int STAT_ARM_BIT  = 1;
  // reset values of software bits
  localparam logic RST_PRESEL  = 1'b0;
  localparam logic RST_URS     = 1'b0;
  localparam logic RST_STOP    = 1'b0;
  localparam logic RST_LSO_OFF = 1'b0;
  ////////////////////////////////////////////////////////////////////////////
  // register select
  typedef enum logic [3:0] {
    WDG_REG_NONE    = 4'b0000,
    WDG_REG_REFRESH = 4'b0001,
    WDG_REG_START   = 4'b0010,
    WDG_REG_WDCTRL  = 4'b0011,
    WDG_REG_PMODE1  = 4'b0100,
    WDG_REG_PROTECT = 4'b0101,
    WDG_REG_CMODE1  = 4'b0110,
    WDG_REG_OPTION  = 4'b0111,
    WDG_REG_COUNT   = 4'b1000,
    WDG_REG_STATUS  = 4'b1001
  } wdg_reg_t;
endpackage

// ---- logic/wdg_tick_div.sv ----
// enable pulse divider standing in for the low-speed oscillator
`timescale 1ns/1ps
module wdg_tick_div #(
  parameter int DIV = wdg_pkg::LSO_DIV
) (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // oscillator running
  input  wire logic en,
  // one-cycle tick
  output logic      tick
);
  localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  if (DIV < 2) begin : g_chk
    $error("wdg_tick_div: DIV below 2");
  end

  typedef struct packed {
    logic [CW-1:0] cnt;   // phase within one osc period
    logic          tick;  // registered pulse
  } wdg_div_state_t;

  wdg_div_state_t st_r;
  wdg_div_state_t st_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // phase holds while stopped, so a restart resumes mid-period
  always_comb begin
    st_nxt      = st_r;
    st_nxt.tick = 1'b0;
    if (en) begin
      if (st_r.cnt == LAST) begin
        st_nxt.cnt  = '0;
        st_nxt.tick = 1'b1;
      end else begin
        st_nxt.cnt = st_r.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign tick = st_r.tick;
endmodule

// ---- logic/wdg_watchdog.sv ----
// watchdog timer with count source protection, apb register slave
`timescale 1ns/1ps
// Behaviour
// - unprotected mode counts on cpu clock
// - prescaler ratio 16 or 128 selectable
// - unprotected period is ratio times 32768
// - write 00h then FFh reloads counter
// - prescaler cleared only by reset
// - option bit picks autostart or start write
// - program cannot change autostart option bit
// - unprotected count freezes in stop/wait/hold
// - underflow gives interrupt or reset per bit
// - protected mode counts on 125 kHz oscillator
// - protected period is 4096 oscillator ticks
// - protected count runs through wait, hold
// - protect enable loads 0FFFh, osc on, reset
// - protected mode ignores stop request writes
// - protected mode ignores oscillator off writes
// - protect option bit zero enables protection
// - counter is fifteen bits wide
module wdg_watchdog #(
  parameter int LSO_DIV = wdg_pkg::LSO_DIV
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // factory option byte, sampled after reset release
  input  wire logic [7:0]  factory_option_byte,
  // cpu low-power and bus states
  input  wire logic        cpu_stop,
  input  wire logic        cpu_wait,
  input  wire logic        cpu_hold,
  // watchdog results and mode outputs
  output logic             wdt_irq,
  output logic             wdt_reset_req,
  output logic             stop_mode_request,
  output logic             low_speed_osc_off,
  output logic             protect_active
);
  if (LSO_DIV < 2) begin : g_chk
    $error("wdg_watchdog: LSO_DIV below 2");
  end

  ////////////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    logic        opt_valid;  // option byte captured
    logic [7:0]  opt;        // captured option byte
    logic        started;    // counter and prescaler running
    logic        protect;    // protection mode active
    logic        presel;     // prescale select, 1 = divide by 128
    logic        urs;        // underflow reset select
    logic        stop_req;   // stop mode request
    logic        lso_off;    // low-speed oscillator off
    logic        armed;      // 00h seen on refresh register
    logic [6:0]  psc;        // prescaler
    logic [14:0] cnt;        // watchdog count
    logic        irq;        // interrupt pulse
    logic        rst;        // reset request pulse
    logic [31:0] rdata;      // read data
  } wdg_state_t;

  wdg_state_t st_r;
  wdg_state_t st_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // address decode, shared by write, read and error logic
  function automatic wdg_pkg::wdg_reg_t wdg_decode(input logic [7:0] a);
    if (a == wdg_pkg::OFF_REFRESH) begin
      return wdg_pkg::WDG_REG_REFRESH;
    end else if (a == wdg_pkg::OFF_START) begin
      return wdg_pkg::WDG_REG_START;
    end else if (a == wdg_pkg::OFF_WDCTRL) begin
      return wdg_pkg::WDG_REG_WDCTRL;
    end else if (a == wdg_pkg::OFF_PMODE1) begin
      return wdg_pkg::WDG_REG_PMODE1;
    end else if (a == wdg_pkg::OFF_PROTECT) begin
      return wdg_pkg::WDG_REG_PROTECT;
    end else if (a == wdg_pkg::OFF_CMODE1) begin
      return wdg_pkg::WDG_REG_CMODE1;
    end else if (a == wdg_pkg::OFF_OPTION) begin
      return wdg_pkg::WDG_REG_OPTION;
    end else if (a == wdg_pkg::OFF_COUNT) begin
      return wdg_pkg::WDG_REG_COUNT;
    end else if (a == wdg_pkg::OFF_STATUS) begin
      return wdg_pkg::WDG_REG_STATUS;
    end else begin
      return wdg_pkg::WDG_REG_NONE;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // bus strobes and count enables
  wdg_pkg::wdg_reg_t sel;          // decoded register
  logic              wr_en;        // write access phase
  logic              rd_setup;     // read setup phase
  logic              frozen;       // cpu in stop, wait or hold
  logic              run_cpu;      // prescaler advancing
  logic [6:0]        psc_mask;     // prescaler wrap mask
  logic              cpu_tick;     // divided cpu clock tick
  logic              lso_tick;     // oscillator tick
  logic              cnt_tick;     // counter decrement enable
  logic              underflow;    // counter wraps this cycle
  logic              refresh_fire; // valid refresh sequence completes
  logic              prot_go;      // protection mode switches on
  logic [14:0]       full_val;     // reload value for current mode

  assign sel      = wdg_decode(paddr);
  assign wr_en    = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign frozen   = cpu_stop | cpu_wait | cpu_hold;
  // no prescaler once protected; low-power freeze only when unprotected
  assign run_cpu  = st_r.started & ~st_r.protect & ~frozen;
  assign psc_mask = st_r.presel ? wdg_pkg::PSC_MASK128 : wdg_pkg::PSC_MASK16;
  assign cpu_tick = run_cpu & ((st_r.psc & psc_mask) == psc_mask);
  assign cnt_tick = st_r.protect ? (st_r.started & lso_tick) : cpu_tick;
  assign underflow = cnt_tick & (st_r.cnt == 15'h0000);
  assign full_val = st_r.protect ? wdg_pkg::FULL_PROT : wdg_pkg::FULL_UNPROT;
  assign refresh_fire = wr_en & (sel == wdg_pkg::WDG_REG_REFRESH) & st_r.armed &
                        (pwdata[7:0] == wdg_pkg::REFRESH_FIRE);
  // strap at release or a software write of one; zero never leaves the mode
  assign prot_go = ~st_r.protect &
                   ((~st_r.opt_valid & ~factory_option_byte[wdg_pkg::OPT_PROT_BIT]) |
                    (wr_en & (sel == wdg_pkg::WDG_REG_PROTECT) &
                     pwdata[wdg_pkg::PROT_BIT]));

  ////////////////////////////////////////////////////////////////////////////
  // oscillator tick, kept alive in protection mode by the locked off bit
  wdg_tick_div #(
    .DIV (LSO_DIV)
  ) u_lso (
    .pclk    (pclk),
    .presetn (presetn),
    .en      (~st_r.lso_off),
    .tick    (lso_tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    st_nxt     = st_r;
    st_nxt.irq = 1'b0;
    st_nxt.rst = 1'b0;
    // option byte caught once after release; no bus path writes it
    if (!st_r.opt_valid) begin
      st_nxt.opt_valid = 1'b1;
      st_nxt.opt       = factory_option_byte;
      st_nxt.started   = ~factory_option_byte[wdg_pkg::OPT_AUTO_BIT];
    end
    // register writes
    if (wr_en) begin
      case (sel)
        wdg_pkg::WDG_REG_REFRESH: begin
          // any value other than 00h drops the half-done sequence
          st_nxt.armed = (pwdata[7:0] == wdg_pkg::REFRESH_ARM);
        end
        wdg_pkg::WDG_REG_START: begin
          st_nxt.started = 1'b1;
        end
        wdg_pkg::WDG_REG_WDCTRL: begin
          st_nxt.presel = pwdata[wdg_pkg::PRESEL_BIT];
        end
        wdg_pkg::WDG_REG_PMODE1: begin
          // reset action is pinned while protected
          st_nxt.urs = st_r.protect | pwdata[wdg_pkg::URS_BIT];
        end
        wdg_pkg::WDG_REG_CMODE1: begin
          if (!st_r.protect) begin
            st_nxt.stop_req = pwdata[wdg_pkg::STOP_BIT];
            st_nxt.lso_off  = pwdata[wdg_pkg::LSO_OFF_BIT];
          end
        end
        default: begin
          // option, count, status and protect are handled elsewhere
        end
      endcase
    end
    // protection switch-on side effects
    if (prot_go) begin
      st_nxt.protect  = 1'b1;
      st_nxt.lso_off  = 1'b0;
      st_nxt.urs      = 1'b1;
      st_nxt.stop_req = 1'b0;
    end
    // prescaler: never cleared by refresh, so first period may run short
    if (run_cpu) begin
      st_nxt.psc = st_r.psc + 7'h01;
    end
    // counter: protect load, then refresh, then ticks
    if (prot_go) begin
      st_nxt.cnt = wdg_pkg::FULL_PROT;
    end else if (refresh_fire) begin
      st_nxt.cnt = full_val;
    end else if (underflow) begin
      st_nxt.cnt = full_val;
      st_nxt.irq = ~st_r.urs & ~st_r.protect;
      st_nxt.rst = st_r.urs | st_r.protect;
    end else if (cnt_tick) begin
      st_nxt.cnt = st_r.cnt - 15'h0001;
    end
    // read data latched in setup, stable through access
    if (rd_setup) begin
      st_nxt.rdata = 32'h0000_0000;
      case (sel)
        wdg_pkg::WDG_REG_WDCTRL:  st_nxt.rdata[wdg_pkg::PRESEL_BIT] = st_r.presel;
        wdg_pkg::WDG_REG_PMODE1:  st_nxt.rdata[wdg_pkg::URS_BIT] = st_r.urs;
        wdg_pkg::WDG_REG_PROTECT: st_nxt.rdata[wdg_pkg::PROT_BIT] = st_r.protect;
        wdg_pkg::WDG_REG_CMODE1: begin
          st_nxt.rdata[wdg_pkg::STOP_BIT]    = st_r.stop_req;
          st_nxt.rdata[wdg_pkg::LSO_OFF_BIT] = st_r.lso_off;
        end
        wdg_pkg::WDG_REG_OPTION:  st_nxt.rdata[7:0] = st_r.opt;
        wdg_pkg::WDG_REG_COUNT:   st_nxt.rdata[14:0] = st_r.cnt;
        wdg_pkg::WDG_REG_STATUS: begin
          st_nxt.rdata[wdg_pkg::STAT_RUN_BIT] = st_r.started;
          st_nxt.rdata[wdg_pkg::STAT_ARM_BIT] = st_r.armed;
        end
        default: st_nxt.rdata = 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register; reset loads constants only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r          <= '0;
      st_r.presel   <= wdg_pkg::RST_PRESEL;
      st_r.urs      <= wdg_pkg::RST_URS;
      st_r.stop_req <= wdg_pkg::RST_STOP;
      st_r.lso_off  <= wdg_pkg::RST_LSO_OFF;
      st_r.cnt      <= wdg_pkg::FULL_UNPROT;
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign prdata            = st_r.rdata;
  assign pready            = 1'b1;
  assign pslverr           = psel & penable & (sel == wdg_pkg::WDG_REG_NONE);
  assign wdt_irq           = st_r.irq;
  assign wdt_reset_req     = st_r.rst;
  assign stop_mode_request = st_r.stop_req;
  assign low_speed_osc_off = st_r.lso_off;
  assign protect_active    = st_r.protect;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_arm;
    wr_en && sel == wdg_pkg::WDG_REG_REFRESH && pwdata[7:0] == wdg_pkg::REFRESH_ARM;
  endsequence
  sequence s_fire;
    wr_en && sel == wdg_pkg::WDG_REG_REFRESH && pwdata[7:0] == wdg_pkg::REFRESH_FIRE;
  endsequence

  // apb writes come at least three cycles apart: access, idle, setup, access
  a_refresh_reload: assert property (
    s_arm ##1 (!wr_en)[*2] ##1 (s_fire and !prot_go)
      |=> st_r.cnt == $past(full_val) && !st_r.armed)
    else $error("refresh sequence did not reload counter");

  a_refresh_strict: assert property (
    (s_fire and !st_r.armed) |=> st_r.cnt != $past(full_val) || $past(underflow)
      || $past(st_r.cnt) == $past(full_val))
    else $error("unarmed ff write reloaded counter");

  a_psc_kept: assert property (
    refresh_fire && run_cpu |=> st_r.psc == $past(st_r.psc) + 7'h01)
    else $error("prescaler disturbed by refresh");

  a_idle_start: assert property (
    st_r.opt_valid && !st_r.started && !wr_en |=> $stable(st_r.cnt) && $stable(st_r.psc))
    else $error("counter moved before start");

  a_freeze_hold: assert property (
    st_r.opt_valid && !st_r.protect && frozen && !wr_en
      |=> st_r.cnt == $past(st_r.cnt) && st_r.psc == $past(st_r.psc))
    else $error("counter moved while frozen");

  a_ratio_16: assert property (
    cpu_tick && !st_r.presel && !wr_en && !frozen ##1 (!frozen && !wr_en)[*8]
      |-> !cpu_tick)
    else $error("divide by 16 tick too early");

  a_irq_pulse: assert property (
    underflow && !st_r.urs && !st_r.protect && !refresh_fire && !prot_go
      |=> wdt_irq && !wdt_reset_req ##1 !wdt_irq)
    else $error("underflow interrupt wrong");

  a_reset_pulse: assert property (
    underflow && (st_r.urs || st_r.protect) && !refresh_fire && !prot_go
      |=> wdt_reset_req && !wdt_irq && st_r.cnt == $past(full_val))
    else $error("underflow reset wrong");

  a_prot_load: assert property (
    prot_go |=> st_r.protect && st_r.cnt == wdg_pkg::FULL_PROT && st_r.urs && !st_r.lso_off)
    else $error("protect entry side effects missing");

  a_prot_runs: assert property (
    st_r.protect && st_r.started && (cpu_wait || cpu_hold) && lso_tick &&
      st_r.cnt != 15'h0000 && !wr_en |=> st_r.cnt == $past(st_r.cnt) - 15'h0001)
    else $error("protected counter stalled");

  a_stop_locked: assert property (
    st_r.protect && wr_en && sel == wdg_pkg::WDG_REG_CMODE1 |=> !stop_mode_request)
    else $error("stop request changed while protected");

  a_osc_locked: assert property (
    st_r.protect |=> !low_speed_osc_off && protect_active)
    else $error("oscillator off or protect dropped");

  // a start write must always leave the counter running
  a_start_run: assert property (
    wr_en && sel == wdg_pkg::WDG_REG_START |=> st_r.started)
    else $error("start write did not start counter");

  // only reset stops a running counter
  a_start_sticky: assert property (
    st_r.started |=> st_r.started)
    else $error("counter stopped without reset");

  // no prescaler in protected mode, so its phase must hold
  a_psc_frozen: assert property (
    st_r.protect |=> $stable(st_r.psc))
    else $error("prescaler moved while protected");

  // reset action stays selected for as long as protection lasts
  a_urs_pinned: assert property (
    st_r.protect |=> st_r.urs)
    else $error("underflow action left reset while protected");

  // a plain tick takes exactly one off the count
  a_cnt_step: assert property (
    cnt_tick && st_r.cnt != 15'h0000 && !refresh_fire && !prot_go
      |=> st_r.cnt == $past(st_r.cnt) - 15'h0001)
    else $error("counter did not step down by one");
endmodule

// ---- verif/wdg_watchdog_bench.sv ----
// self-checking bench for the watchdog timer and its apb registers
`timescale 1ns/1ps
module wdg_watchdog_bench;
  ////////////////////////////////////////////////////////////////////////////
  // a short oscillator divide keeps protected-mode underflow within the run
  localparam int DIV = 4;
  // clock, reset and apb
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  // option strap and cpu states
  logic [7:0]  factory_option_byte;
  logic        cpu_stop;
  logic        cpu_wait;
  logic        cpu_hold;
  // watchdog results
  logic        wdt_irq;
  logic        wdt_reset_req;
  logic        stop_mode_request;
  logic        low_speed_osc_off;
  logic        protect_active;
  // bookkeeping
  int          err_total;
  int          n_compared;
  int          irq_seen;
  int          n;
  logic [31:0] q;
  logic [31:0] c0;
  logic        e;
  logic [7:0]  bad;
  ////////////////////////////////////////////////////////////////////////////
  wdg_watchdog #(.LSO_DIV(DIV)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .factory_option_byte(factory_option_byte), .cpu_stop(cpu_stop), .cpu_wait(cpu_wait),
    .cpu_hold(cpu_hold), .wdt_irq(wdt_irq), .wdt_reset_req(wdt_reset_req),
    .stop_mode_request(stop_mode_request), .low_speed_osc_off(low_speed_osc_off),
    .protect_active(protect_active)
  );
  // 200 mhz clock
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  // count interrupt pulses; protected runs must never give one
  always @(posedge pclk) begin
    if (presetn === 1'b1 && wdt_irq === 1'b1) begin
      irq_seen++;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // counts, verdict and end of run
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // range compare; an unknown never lands inside the range
  task automatic chk(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    n_compared++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      err_total++;
      $display("FAIL at %0t got %h expected %h..%h", $time, got, lo, hi);
    end
  endtask
  // one apb transfer; request held until pready is seen high at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      $display("FAIL at %0t pready wait %h reached limit %h", $time, k, 20);
      err_total++;
      summarize();
    end
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  // reset held three cycles, strap applied meanwhile
  task automatic do_reset(input logic [7:0] opt);
    presetn             <= 1'b0;
    factory_option_byte <= opt;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask
  // ticks between two count reads; the slack covers the unknown prescaler phase
  task automatic rate(input int per);
    int w;
    w = 200 + int'($urandom % 300);
    apb(1'b0, wdg_pkg::OFF_COUNT, 32'h0000_0000);
    c0 = q;
    repeat (w) @(posedge pclk);
    apb(1'b0, wdg_pkg::OFF_COUNT, 32'h0000_0000);
    chk(c0 - q, (w + 3) / per, (w + 3) / per + 1);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    factory_option_byte = 8'hFF;
    cpu_stop = 1'b0;
    cpu_wait = 1'b0;
    cpu_hold = 1'b0;
    err_total = 0;
    n_compared = 0;
    irq_seen = 0;
    void'($urandom(32'h19ad_a88e));
    // stopped after reset; read-only option; unmapped place refused
    do_reset(8'hFF);
    repeat (100) @(posedge pclk);
    apb(1'b0, wdg_pkg::OFF_COUNT, 32'h0000_0000);
    chk(q, 32'h0000_7FFF, 32'h0000_7FFF);
    apb(1'b1, wdg_pkg::OFF_OPTION, 32'h0000_0000);
    apb(1'b0, wdg_pkg::OFF_OPTION, 32'h0000_0000);
    chk(q, 32'h0000_00FF, 32'h0000_00FF);
    apb(1'b0, 8'h3C, 32'h0000_0000);
    chk({31'h0000_0000, e}, 32'h0000_0001, 32'h0000_0001);
    $display("test reset_stopped done");
    // start write with random data, then cpu clock over sixteen
    apb(1'b1, wdg_pkg::OFF_START, $urandom);
    rate(16);
    $display("test start_rate done");
    // an intervening value breaks the pair; another register does not
    bad = 8'($urandom_range(254, 1));
    apb(1'b1, wdg_pkg::OFF_REFRESH, 32'h0000_0000);
    apb(1'b1, wdg_pkg::OFF_REFRESH, {24'h00_0000, bad});
    apb(1'b1, wdg_pkg::OFF_REFRESH, 32'h0000_00FF);
    apb(1'b0, wdg_pkg::OFF_COUNT, 32'h0000_0000);
    chk(q, 32'h0000_0000, 32'h0000_7FFD);
    apb(1'b1, wdg_pkg::OFF_REFRESH, 32'h0000_0000);
    apb(1'b1, wdg_pkg::OFF_WDCTRL, 32'h0000_0080);
    apb(1'b1, wdg_pkg::OFF_REFRESH, 32'h0000_00FF);
    apb(1'b0, wdg_pkg::OFF_COUNT, 32'h0000_0000);
    chk(q, 32'h0000_7FFE, 32'h0000_7FFF);
    rate(128);
    $display("test refresh done");
    // each low-power or bus state freezes the count, which then resumes
    for (int i = 0; i < 3; i++) begin
      @(posedge pclk);
      cpu_stop <= (i == 0);
      cpu_wait <= (i == 1);
      cpu_hold <= (i == 2);
      apb(1'b0, wdg_pkg::OFF_COUNT, 32'h0000_0000);
      c0 = q;
      repeat (300) @(posedge pclk);
      apb(1'b0, wdg_pkg::OFF_COUNT, 32'h0000_0000);
      chk(q, c0, c0);
    end
    cpu_hold <= 1'b0;
    rate(128);
    $display("test freeze done");
    // unprotected: stop request and oscillator off are writable
    apb(1'b1, wdg_pkg::OFF_CMODE1, 32'h0000_0011);
    apb(1'b0, wdg_pkg::OFF_CMODE1, 32'h0000_0000);
    chk(q, 32'h0000_0011, 32'h0000_0011);
    chk({30'h0000_0000, stop_mode_request, low_speed_osc_off}, 32'h3, 32'h3);
    // protection entry loads, turns the oscillator on, selects reset
    apb(1'b1, wdg_pkg::OFF_PROTECT, 32'h0000_0080);
    apb(1'b0, wdg_pkg::OFF_COUNT, 32'h0000_0000);
    chk(q, 32'h0000_0FFE, 32'h0000_0FFF);
    chk({29'h0, protect_active, stop_mode_request, low_speed_osc_off}, 32'h4, 32'h4);
    apb(1'b0, wdg_pkg::OFF_PMODE1, 32'h0000_0000);
    chk(q, 32'h0000_0004, 32'h0000_0004);
    // protected writes that must leave the mode untouched
    apb(1'b1, wdg_pkg::OFF_CMODE1, 32'h0000_0011);
    apb(1'b1, wdg_pkg::OFF_PROTECT, 32'h0000_0000);
    apb(1'b1, wdg_pkg::OFF_PMODE1, 32'h0000_0000);
    apb(1'b0, wdg_pkg::OFF_CMODE1, 32'h0000_0000);
    chk(q, 32'h0000_0000, 32'h0000_0000);
    apb(1'b0, wdg_pkg::OFF_PROTECT, 32'h0000_0000);
    chk(q, 32'h0000_0080, 32'h0000_0080);
    // oscillator count runs through every cpu state
    cpu_stop <= 1'b1;
    cpu_wait <= 1'b1;
    cpu_hold <= 1'b1;
    rate(DIV);
    // refresh, then time the underflow reset from the reload
    apb(1'b1, wdg_pkg::OFF_REFRESH, 32'h0000_0000);
    apb(1'b1, wdg_pkg::OFF_REFRESH, 32'h0000_00FF);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (wdt_reset_req !== 1'b1 && n < 20000);
    if (n >= 20000) begin
      $display("FAIL at %0t reset wait %h reached limit %h", $time, n, 20000);
      err_total++;
      summarize();
    end
    chk(n, 4096 * DIV - DIV, 4096 * DIV + DIV);
    @(posedge pclk);
    chk({31'h0000_0000, wdt_reset_req}, 32'h0, 32'h0);
    chk(irq_seen, 32'h0, 32'h0);
    cpu_stop <= 1'b0;
    cpu_wait <= 1'b0;
    cpu_hold <= 1'b0;
    $display("test protected done");
    // mid-run reset with both straps low: protected and counting at once
    do_reset(8'h7E);
    apb(1'b0, wdg_pkg::OFF_STATUS, 32'h0000_0000);
    chk(q, 32'h0000_0001, 32'h0000_0001);
    chk({31'h0000_0000, protect_active}, 32'h1, 32'h1);
    rate(DIV);
    $display("test strap_protect done");
    summarize();
  end
endmodule
